// ### host_port_consts.svh
// Offsets, field positions, reset values and timing counts of the host port
`ifndef HOST_PORT_CONSTS_SVH
`define HOST_PORT_CONSTS_SVH
`define MASTER_CONTROL_STATUS_OFS      2'h0
`define LOWER_INDIRECT_ADDRESS_OFS     2'h1
`define ADDRESS_MODE_UPPER_ADDRESS_OFS 2'h2
`define INDIRECT_DATA_OFS              2'h3
`define BIT_SOFTWARE_RESET             7
`define BIT_CLOCK_ERROR_CLEAR          6
`define BIT_SYSTEM_ERROR_CLEAR         5
`define BIT_ACTIVE_PAGE                4
`define BIT_TELECOM_ENABLE             3
`define BIT_LOCAL_OUTPUT_ENABLE        2
`define BIT_LOCAL_FUNCTION_ENABLE      1
`define BIT_CAM_BUSY                   0
`define REG_RESET_VALUE                8'h00
`define WO_READ_VALUE                  8'h00
`define CLK_PERIOD_NS                  4
`define RESET_HOLD_NS                  32
`define RESET_HOLD_CYCLES              ((`RESET_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ### host_port_pkg.sv
// Types shared by the host port design
package host_port_pkg;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_WAIT = 2'b01,
    S_ACK  = 2'b10
  } port_state_t;
endpackage

// ### indirect_host_port_master_control.sv
// Host port: four direct registers, master control bits, indirect access engine
`timescale 1ns/1ps
`include "host_port_consts.svh"
`default_nettype none

module indirect_host_port_master_control (
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       bus_mode_rd_wr,
  input  wire logic       chip_select_b,
  input  wire logic       read_strobe_b,
  input  wire logic       write_strobe_b,
  input  wire logic [1:0] register_select,
  input  wire logic [7:0] host_data_in,
  output logic      [7:0] host_data_out,
  output logic            host_data_oe,
  output logic            transfer_ready_ack,
  output logic            transfer_ready_ack_oe,
  output logic      [7:0] indirect_space,
  output logic      [7:0] indirect_index,
  output logic      [7:0] indirect_wdata,
  output logic            indirect_request,
  output logic            indirect_write,
  input  wire logic [7:0] indirect_rdata,
  input  wire logic       indirect_done,
  input  wire logic       cam_access_busy,
  output logic            software_reset_request,
  output logic            clock_error_clear_request,
  output logic            system_error_clear_request,
  output logic            active_buffer_page,
  output logic            telecom_bus_output_enable,
  output logic            local_output_enable,
  output logic            local_function_enable,
  output logic            test_clock_enable
);

  localparam int unsigned SYNC_W = 14;
  localparam logic [3:0] HOLD_CYCLES = 4'(`RESET_HOLD_CYCLES);

  logic [SYNC_W-1:0]       sync_meta;
  logic [SYNC_W-1:0]       sync_pins;
  logic                    mode_rd_wr;
  logic                    cs_b_s;
  logic                    rd_b_s;
  logic                    wr_b_s;
  logic [1:0]              sel_s;
  logic [7:0]              din_s;
  logic                    strobe;
  logic                    is_read;
  logic                    start;
  logic                    wr_start;
  host_port_pkg::port_state_t state;
  host_port_pkg::port_state_t next_state;
  logic [7:0]              lower_indirect_address;
  logic [7:0]              address_mode_upper_address;
  logic [4:1]              ctl;
  logic [2:0]              req;
  logic [2:0]              req_set;
  logic                    cam_busy_q;

  // Every pin, strap included, passes two flops; the first feeds only the second
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync_meta <= '1;
      sync_pins <= '1;
    end
    else
    begin
      sync_meta <= {bus_mode_rd_wr, chip_select_b, read_strobe_b, write_strobe_b,
                    register_select, host_data_in};
      sync_pins <= sync_meta;
    end
  end

  assign mode_rd_wr = sync_pins[13];
  assign cs_b_s     = sync_pins[12];
  assign rd_b_s     = sync_pins[11];
  assign wr_b_s     = sync_pins[10];
  assign sel_s      = sync_pins[9:8];
  assign din_s      = sync_pins[7:0];

  // Strobe decode for both conventions; chip select gates everything
  // Mode high: read and write strobes. Mode low: data strobe plus read/write level.
  assign strobe   = !cs_b_s && (mode_rd_wr ? (!rd_b_s || !wr_b_s) : !rd_b_s);
  assign is_read  = mode_rd_wr ? !rd_b_s : wr_b_s;
  assign start    = strobe && (state == host_port_pkg::S_IDLE);
  assign wr_start = start && !is_read;

  // Access sequencer: one access per strobe, ack held until strobe released
  always_comb
  begin
    next_state = state;
    unique case (state)
      host_port_pkg::S_IDLE:
      begin
        if (start)
          next_state = (sel_s == `INDIRECT_DATA_OFS) ? host_port_pkg::S_WAIT : host_port_pkg::S_ACK;
      end
      host_port_pkg::S_WAIT:
      begin
        if (indirect_done)
          next_state = host_port_pkg::S_ACK;
      end
      host_port_pkg::S_ACK:
      begin
        if (!strobe)
          next_state = host_port_pkg::S_IDLE;
      end
      default:
        next_state = host_port_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      state <= host_port_pkg::S_IDLE;
    else
      state <= next_state;
  end

  // Address registers; software reset clears them, reads never touch them
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lower_indirect_address     <= `REG_RESET_VALUE;
      address_mode_upper_address <= `REG_RESET_VALUE;
    end
    else if (wr_start && sel_s == `MASTER_CONTROL_STATUS_OFS && din_s[`BIT_SOFTWARE_RESET])
    begin
      lower_indirect_address     <= `REG_RESET_VALUE;
      address_mode_upper_address <= `REG_RESET_VALUE;
    end
    else if (wr_start && sel_s == `LOWER_INDIRECT_ADDRESS_OFS)
      lower_indirect_address <= din_s;
    else if (wr_start && sel_s == `ADDRESS_MODE_UPPER_ADDRESS_OFS)
      address_mode_upper_address <= din_s;
  end

  // Control bits 4..1; a software reset write drops them all
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      ctl <= '0;
    else if (wr_start && sel_s == `MASTER_CONTROL_STATUS_OFS)
      ctl <= din_s[`BIT_SOFTWARE_RESET] ? 4'h0 : din_s[4:1];
  end

  // Request bits 5..7, each with its own hold counter; a new set wins over the clear
  always_comb
  begin
    req_set = '0;
    if (wr_start && sel_s == `MASTER_CONTROL_STATUS_OFS)
      req_set = din_s[7:5];
  end

  for (genvar i = 0; i < 3; i++)
  begin : g_req
    logic [3:0] hold;
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
      if (!rst_b)
      begin
        req[i] <= 1'b0;
        hold   <= 4'h0;
      end
      else if (req_set[i])
      begin
        req[i] <= 1'b1;
        hold   <= HOLD_CYCLES;
      end
      else if (req[i])
      begin
        hold   <= hold - 4'h1;
        req[i] <= (hold != 4'h1);
      end
    end
  end

  // Indirect engine: space and index go straight from the address registers
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      indirect_request <= 1'b0;
      indirect_write   <= 1'b0;
      indirect_wdata   <= 8'h00;
    end
    else if (start && sel_s == `INDIRECT_DATA_OFS)
    begin
      indirect_request <= 1'b1;
      indirect_write   <= !is_read;
      indirect_wdata   <= din_s;
    end
    else if (indirect_done)
      indirect_request <= 1'b0;
  end

  // Space zero with the index picks a control register elsewhere in the device
  assign indirect_space = address_mode_upper_address;
  assign indirect_index = lower_indirect_address;

  // Busy is sampled so the read value is taken from a flop, not a live input
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      cam_busy_q <= 1'b0;
    else
      cam_busy_q <= cam_access_busy;
  end

  // Read data; write-only registers answer with a filler value
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      host_data_out <= 8'h00;
    else if (start && is_read)
    begin
      unique case (sel_s)
        `MASTER_CONTROL_STATUS_OFS: host_data_out <= {req[2:0], ctl, cam_busy_q};
        `INDIRECT_DATA_OFS:         host_data_out <= host_data_out;
        default:                    host_data_out <= `WO_READ_VALUE;
      endcase
    end
    else if (state == host_port_pkg::S_WAIT && indirect_done && !indirect_write)
      host_data_out <= indirect_rdata;
  end

  // Drive the data bus only during a selected read
  assign host_data_oe = strobe && is_read && (state == host_port_pkg::S_ACK);

  // Ready pin is open drain: mode high pulls low while not ready, mode low pulls low to ack
  assign transfer_ready_ack    = 1'b0;
  assign transfer_ready_ack_oe = mode_rd_wr ? (strobe && state != host_port_pkg::S_ACK)
                                            : (strobe && state == host_port_pkg::S_ACK);

  // Device-facing controls
  assign software_reset_request     = req[2];
  assign clock_error_clear_request  = req[1];
  assign system_error_clear_request = req[0];
  assign active_buffer_page         = ctl[`BIT_ACTIVE_PAGE];
  assign telecom_bus_output_enable  = ctl[`BIT_TELECOM_ENABLE];
  assign local_output_enable        = ctl[`BIT_LOCAL_OUTPUT_ENABLE];
  assign local_function_enable      = ctl[`BIT_LOCAL_FUNCTION_ENABLE];
  assign test_clock_enable          = !req[2];

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  property p_mcr_write;
    wr_start && sel_s == 2'h0 && !din_s[7] |=> ctl == $past(din_s[4:1]);
  endproperty
  a_mcr_write: assert property (p_mcr_write) else $error("control bits not loaded");

  property p_lar_write;
    wr_start && sel_s == 2'h1 |=> indirect_index == $past(din_s);
  endproperty
  a_lar_write: assert property (p_lar_write) else $error("lower address not loaded");

  property p_amr_write;
    wr_start && sel_s == 2'h2 |=> indirect_space == $past(din_s);
  endproperty
  a_amr_write: assert property (p_amr_write) else $error("address mode not loaded");

  property p_idr_request;
    start && sel_s == 2'h3 |=> indirect_request && indirect_write == $past(!is_read);
  endproperty
  a_idr_request: assert property (p_idr_request) else $error("indirect access not issued");

  property p_sw_reset;
    wr_start && sel_s == 2'h0 && din_s[7] |=> ctl == 4'h0 && indirect_space == 8'h00 && indirect_index == 8'h00
      && software_reset_request && !telecom_bus_output_enable;
  endproperty
  a_sw_reset: assert property (p_sw_reset) else $error("software reset did not clear registers");

  property p_self_clear;
    $rose(clock_error_clear_request) ##0 (!req_set[1]) [*8] |->
      clock_error_clear_request ##1 !clock_error_clear_request;
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("clear request did not end on time");

  property p_test_clock;
    software_reset_request |-> !test_clock_enable;
  endproperty
  a_test_clock: assert property (p_test_clock) else $error("test clock on during reset");

  property p_busy_read;
    start && is_read && sel_s == 2'h0 |=> host_data_out[0] == $past(cam_busy_q);
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy bit wrong on read");

  property p_wo_read;
    start && is_read && (sel_s == 2'h1 || sel_s == 2'h2) |=> $stable(indirect_index) && $stable(indirect_space)
      && host_data_out == 8'h00;
  endproperty
  a_wo_read: assert property (p_wo_read) else $error("write-only read disturbed state");

  property p_ready;
    state == host_port_pkg::S_WAIT && strobe |-> transfer_ready_ack_oe == mode_rd_wr;
  endproperty
  a_ready: assert property (p_ready) else $error("ready pin wrong while waiting");

  c_idr_read:  cover property (start && is_read && sel_s == 2'h3 ##[1:20] state == host_port_pkg::S_ACK);
  c_sw_reset:  cover property ($fell(software_reset_request));
  c_mcr_read:  cover property (start && is_read && sel_s == 2'h0);
  c_mode_low:  cover property (!mode_rd_wr && state == host_port_pkg::S_ACK);

endmodule

`default_nettype wire

// ### host_model.sv
// Host processor model driving the parallel register port
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       clk_sys,
  input  wire logic       bus_mode_rd_wr,
  output logic            chip_select_b,
  output logic            read_strobe_b,
  output logic            write_strobe_b,
  output logic      [1:0] register_select,
  output logic      [7:0] host_data_in,
  input  wire logic [7:0] host_data_out,
  input  wire logic       host_data_oe,
  input  wire logic       transfer_ready_ack,
  input  wire logic       transfer_ready_ack_oe
);
  logic       ready_pin;
  logic [7:0] data_pins;

  // Open-drain ready and data lines fall back to their pull-ups when undriven
  assign ready_pin = transfer_ready_ack_oe ? transfer_ready_ack : 1'b1;
  assign data_pins = host_data_oe ? host_data_out : 8'hFF;

  // Idle bus: strobes high, data lines float to their pull-ups
  initial
  begin
    chip_select_b = 1'b1;
    read_strobe_b = 1'b1;
    write_strobe_b = 1'b1;
    register_select = 2'h0;
    host_data_in = 8'hFF;
  end

  // One access; select and data settle two cycles before the strobe
  task automatic access(input logic rd, input logic [1:0] sel, input logic [7:0] wd, input logic no_cs,
                        output logic [7:0] rdata, output logic ok);
    int n;
    begin
      n = 0;
      rdata = 8'hFF;
      @(posedge clk_sys);
      #1;
      register_select = sel;
      host_data_in = rd ? 8'hFF : wd;
      if (!bus_mode_rd_wr)
        write_strobe_b = rd;
      repeat (2) @(posedge clk_sys);
      #1;
      chip_select_b = no_cs;
      if (!bus_mode_rd_wr || rd)
        read_strobe_b = 1'b0;
      else
        write_strobe_b = 1'b0;
      if (no_cs)
        repeat (8) @(posedge clk_sys);
      // Separate strobes: pin pulled low while pending, its release means ready
      else if (bus_mode_rd_wr)
      begin
        while (ready_pin !== 1'b0 && n < 200)
        begin
          @(posedge clk_sys);
          n++;
        end
        while (ready_pin !== 1'b1 && n < 200)
        begin
          @(posedge clk_sys);
          n++;
        end
      end
      // Data strobe mode: the pin pulled low is the acknowledge
      else
        while (ready_pin !== 1'b0 && n < 200)
        begin
          @(posedge clk_sys);
          n++;
        end
      // Data taken at the edge that shows ready, as the pins carry it
      rdata = data_pins;
      ok = (n < 200);
      #1;
      chip_select_b = 1'b1;
      read_strobe_b = 1'b1;
      write_strobe_b = 1'b1;
      host_data_in = 8'hFF;
      repeat (2) @(posedge clk_sys);
      #1;
    end
  endtask
endmodule
`default_nettype wire

// ### testbench.sv
// Testbench for the host port: register map, control bits and indirect access
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       clk_sys, rst_b, bus_mode_rd_wr, cs_b, rd_b, wr_b, oe, ack, ack_oe, i_req, i_wr, i_done, cam_busy;
  logic       sw_rst, ce_clr, se_clr, page, tb_en, lo_en, lf_en, tck_en, got_wr;
  logic [1:0] sel, phase;
  logic [7:0] din, dout, space, index, wdata, rdata, got_space, got_index, got_wdata, resp_data, v;
  logic [7:0] ctl;
  int         resp_delay, cnt, num_errors, num_checks;

  assign ctl = {sw_rst, ce_clr, se_clr, page, tb_en, lo_en, lf_en, tck_en};

  indirect_host_port_master_control i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .bus_mode_rd_wr(bus_mode_rd_wr),
    .chip_select_b(cs_b), .read_strobe_b(rd_b), .write_strobe_b(wr_b), .register_select(sel),
    .host_data_in(din), .host_data_out(dout), .host_data_oe(oe), .transfer_ready_ack(ack),
    .transfer_ready_ack_oe(ack_oe), .indirect_space(space), .indirect_index(index), .indirect_wdata(wdata),
    .indirect_request(i_req), .indirect_write(i_wr), .indirect_rdata(rdata), .indirect_done(i_done),
    .cam_access_busy(cam_busy), .software_reset_request(sw_rst), .clock_error_clear_request(ce_clr),
    .system_error_clear_request(se_clr), .active_buffer_page(page), .telecom_bus_output_enable(tb_en),
    .local_output_enable(lo_en), .local_function_enable(lf_en), .test_clock_enable(tck_en));

  host_model i_host (.clk_sys(clk_sys), .bus_mode_rd_wr(bus_mode_rd_wr), .chip_select_b(cs_b),
    .read_strobe_b(rd_b), .write_strobe_b(wr_b), .register_select(sel), .host_data_in(din),
    .host_data_out(dout), .host_data_oe(oe), .transfer_ready_ack(ack), .transfer_ready_ack_oe(ack_oe));

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Indirect target; read data toggles outside the done pulse so stale data is caught
  always @(posedge clk_sys)
  begin
    i_done <= 1'b0;
    rdata <= ~rdata;
    if (!rst_b)
    begin
      phase <= 2'd0;
      cnt <= 0;
      rdata <= 8'h00;
    end
    else
    begin
      case (phase)
        2'd0:
          if (i_req === 1'b1)
          begin
            phase <= 2'd1;
            cnt <= resp_delay;
            {got_wr, got_space, got_index, got_wdata} <= {i_wr, space, index, wdata};
          end
        2'd1:
          if (cnt == 0)
          begin
            i_done <= 1'b1;
            rdata <= resp_data;
            phase <= 2'd2;
          end
          else
            cnt <= cnt - 1;
        default:
          if (i_req !== 1'b1)
            phase <= 2'd0;
      endcase
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic acc(input logic r, input logic [1:0] s, input logic [7:0] d, input logic nc, output logic [7:0] q);
    logic ok;
    i_host.access(r, s, d, nc, q, ok);
    check({7'h0, ok}, 8'h01);
  endtask

  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    acc(1'b0, s, d, 1'b0, v);
    check(v, 8'hFF);
  endtask

  task automatic results;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    {rst_b, bus_mode_rd_wr, cam_busy, resp_data} = {3'b010, 8'h00};
    {resp_delay, num_errors, num_checks} = '0;
    repeat (4) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    acc(1'b1, 2'h0, 8'h00, 1'b0, v);
    check(v, 8'h00);
    check(ctl, 8'h01);
    check(space | index, 8'h00);
    // Each control bit 1..4 alone; test clock stays on whatever they hold
    for (int b = 1; b < 5; b++)
    begin
      wr(2'h0, 8'h01 << b);
      check(ctl, (8'h01 << b) | 8'h01);
      acc(1'b1, 2'h0, 8'h00, 1'b0, v);
      check(v, 8'h01 << b);
    end
    cam_busy = 1'b1;
    acc(1'b1, 2'h0, 8'h00, 1'b0, v);
    check(v, 8'h11);
    cam_busy = 1'b0;
    wr(2'h1, 8'h5A);
    wr(2'h2, 8'h3C);
    check(index, 8'h5A);
    check(space, 8'h3C);
    acc(1'b1, 2'h1, 8'h00, 1'b0, v);
    check(v, 8'h00);
    acc(1'b1, 2'h2, 8'h00, 1'b0, v);
    check(v | (space ^ 8'h3C) | (index ^ 8'h5A), 8'h00);
    wr(2'h2, 8'h00);
    wr(2'h3, 8'hC3);
    check({7'h0, got_wr}, 8'h01);
    check(got_space, 8'h00);
    check(got_index, 8'h5A);
    check(got_wdata, 8'hC3);
    {resp_delay, resp_data} = {32'd6, 8'h96};
    acc(1'b1, 2'h3, 8'h00, 1'b0, v);
    check(v, 8'h96);
    {resp_delay, resp_data} = {32'd0, 8'h69};
    acc(1'b1, 2'h3, 8'h00, 1'b0, v);
    check({7'h0, got_wr}, 8'h00);
    check(v, 8'h69);
    // Error clears pulse then drop by themselves
    wr(2'h0, 8'h7E);
    check(ctl, 8'h7F);
    repeat (12) @(posedge clk_sys);
    check(ctl, 8'h1F);
    wr(2'h0, 8'h80);
    check(ctl, 8'h80);
    check(index | space, 8'h00);
    repeat (12) @(posedge clk_sys);
    check(ctl, 8'h01);
    acc(1'b0, 2'h0, 8'h08, 1'b1, v);
    check(ctl, 8'h01);
    bus_mode_rd_wr = 1'b0;
    repeat (4) @(posedge clk_sys);
    wr(2'h0, 8'h04);
    acc(1'b1, 2'h0, 8'h00, 1'b0, v);
    check(v, 8'h04);
    {resp_delay, resp_data} = {32'd3, 8'hA5};
    acc(1'b1, 2'h3, 8'h00, 1'b0, v);
    check(v, 8'hA5);
    results;
  end

  // Whole run needs a few hundred cycles
  initial
  begin
    #40000;
    num_errors++;
    results;
  end
endmodule
`default_nettype wire
